/* File: rtl/tpd_decode.sv */
// parcel walker and two-parcel format decoder with register zero operands
// assumes fetch words arrive with valid/ready and register reads answer
// combinationally on the designator outputs in the same cycle
`timescale 1ns/1ps
`default_nettype none
module tpd_decode (
    input  wire logic                           i_clk,          // cpu clock
    input  wire logic                           i_nrst,         // sync reset
    input  wire logic                           i_word_valid,   // fetch word offered
    input  wire logic [tpd_pkg::WORD_W-1:0]     i_word,         // four parcels
    output logic                                o_word_ready,   // word taken
    input  wire logic                           i_redirect,     // branch taken
    input  wire logic [1:0]                     i_redirect_parcel, // start parcel
    output logic [2:0]                          o_rd_h,         // read address h
    output logic [2:0]                          o_rd_i,         // read address i
    output logic [2:0]                          o_rd_j,         // read address j
    output logic [2:0]                          o_rd_k,         // read address k
    input  wire logic [tpd_pkg::A_W-1:0]        i_ah_data,      // a[h] contents
    input  wire logic [tpd_pkg::A_W-1:0]        i_ai_data,      // a[i] contents
    input  wire logic [tpd_pkg::A_W-1:0]        i_aj_data,      // a[j] contents
    input  wire logic [tpd_pkg::A_W-1:0]        i_ak_data,      // a[k] contents
    input  wire logic [tpd_pkg::S_W-1:0]        i_si_data,      // s[i] contents
    input  wire logic [tpd_pkg::S_W-1:0]        i_sj_data,      // s[j] contents
    input  wire logic [tpd_pkg::S_W-1:0]        i_sk_data,      // s[k] contents
    output logic                                o_issue,        // one-cycle issue
    output tpd_pkg::tpd_fmt_e                   o_format,       // issued format
    output logic [6:0]                          o_gh,           // opcode g and h
    output logic [2:0]                          o_h,            // index / dest
    output logic [2:0]                          o_i,            // result register
    output logic [tpd_pkg::IMM22_W-1:0]         o_imm22,        // jkm field
    output logic [tpd_pkg::IMM24_W-1:0]         o_imm24,        // ijkm field
    output logic [tpd_pkg::IMM24_W-1:0]         o_target,       // parcel target
    output logic [tpd_pkg::A_W-1:0]             o_ah,           // a index operand
    output logic [tpd_pkg::A_W-1:0]             o_ai,           // a i operand
    output logic [tpd_pkg::A_W-1:0]             o_aj,           // a j operand
    output logic [tpd_pkg::A_W-1:0]             o_ak,           // a k operand
    output logic [tpd_pkg::S_W-1:0]             o_si,           // s i operand
    output logic [tpd_pkg::S_W-1:0]             o_sj,           // s j operand
    output logic [tpd_pkg::S_W-1:0]             o_sk,           // s k operand
    output logic                                o_chk_ah,       // check a[h]
    output logic                                o_chk_aj,       // check a[j]
    output logic                                o_chk_ak,       // check a[k]
    output logic                                o_chk_sj,       // check s[j]
    output logic                                o_chk_sk,       // check s[k]
    output logic                                o_veclen_we,    // vector length write
    output logic [tpd_pkg::VECLEN_W-1:0]        o_veclen_data   // vector length value
);
    import tpd_pkg::*;

    // assertions sample on the cpu clock and rest while reset is low
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    logic [WORD_W-1:0]   word_q;                // current fetch word
    logic                word_vld_q;            // word_q holds parcels
    logic [1:0]          ptr_q;                 // next parcel position
    logic [1:0]          ptr_d;
    logic [PARCEL_W-1:0] first_q;               // leading parcel of a split
    tpd_state_e          state_q;               // run or waiting for second half
    logic [PARCEL_W-1:0] parcel [4];            // word split into parcels
    logic [PARCEL_W-1:0] cur;                   // parcel at ptr_q
    logic [PARCEL_W-1:0] nxt;                   // parcel after ptr_q
    logic                cur_two;               // cur opens a two-parcel
    logic                issue_one;             // one-parcel issue
    logic                issue_in;              // two-parcel within one word
    logic                split;                 // two-parcel crosses a word
    logic                issue_sp;              // second half of a split
    logic                issue;                 // any issue this cycle
    logic                word_done;             // last parcel of word used
    logic                load;                  // fetch word accepted
    logic [INST_W-1:0]   inst;                  // joined instruction
    tpd_fmt_e            fmt;                   // decoded format
    logic [A_W-1:0]      ah_v, aj_v, ak_v;      // substituted a operands
    logic [S_W-1:0]      sj_v, sk_v;            // substituted s operands
    logic                ah_c, aj_c, ak_c;      // a reservation checks
    logic                sj_c, sk_c;            // s reservation checks

    // parcel 0 is the leftmost, most significant quarter of a word
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            parcel[n] = word_q[WORD_W-1-PARCEL_W*n -: PARCEL_W];
        end
        cur     = parcel[ptr_q];
        nxt     = parcel[2'(ptr_q + 2'h1)];
        cur_two = tpd_two_parcel(cur);
    end

    // issue decisions; a split holds issue until the next word lands
    always_comb begin
        issue_one = (state_q == ST_RUN) && word_vld_q && !cur_two;
        issue_in  = (state_q == ST_RUN) && word_vld_q && cur_two && (ptr_q != 2'h3);
        split     = (state_q == ST_RUN) && word_vld_q && cur_two && (ptr_q == 2'h3);
        issue_sp  = (state_q == ST_SPLIT) && word_vld_q;
        issue     = issue_one || issue_in || issue_sp;
        word_done = (issue_one && ptr_q == 2'h3) || (issue_in && ptr_q[1]) || split;
        o_word_ready = !word_vld_q || word_done;
        load      = i_word_valid && o_word_ready && !i_redirect;
    end

    // join the parcels of the instruction being issued
    always_comb begin
        if (issue_sp) begin
            inst = {first_q, parcel[0]};        // second parcel from next word
        end else if (cur_two) begin
            inst = {cur, nxt};
        end else begin
            inst = {cur, 16'h0000};
        end
    end

    // format by opcode; the i top bit separates the 24-bit constant
    always_comb begin
        fmt = FMT_ONE;
        if (!issue_sp && !cur_two) begin
            fmt = FMT_ONE;
        end else if (inst[31:28] == G_IMM24 && inst[F_ITOP]) begin
            fmt = FMT_IMM24;
        end else if (inst[31:25] == GH_IMM22_A || inst[31:25] == GH_IMM22_S) begin
            fmt = FMT_IMM22;
        end else if (inst[31:28] >= G_MEM_LO && inst[31:28] <= G_MEM_HI) begin
            fmt = FMT_MEM;
        end else begin
            fmt = FMT_BRANCH;
        end
    end

    // designators go straight to the register file read ports
    always_comb begin
        o_rd_h = inst[F_H_LO +: 3];
        o_rd_i = inst[F_I_LO +: 3];
        o_rd_j = inst[F_J_LO +: 3];
        o_rd_k = inst[F_K_LO +: 3];
    end

    // register zero substitution; j and k only as one-parcel operands
    tpd_zero_sub #(.W(A_W), .SPECIAL(A_SPECIAL_H)) u_ah (
        .i_desig  (o_rd_h),
        .i_enable (fmt == FMT_MEM),
        .i_data   (i_ah_data),
        .o_value  (ah_v),
        .o_check  (ah_c)
    );
    tpd_zero_sub #(.W(A_W), .SPECIAL(A_SPECIAL_J)) u_aj (
        .i_desig  (o_rd_j),
        .i_enable (fmt == FMT_ONE),
        .i_data   (i_aj_data),
        .o_value  (aj_v),
        .o_check  (aj_c)
    );
    tpd_zero_sub #(.W(A_W), .SPECIAL(A_SPECIAL_K)) u_ak (
        .i_desig  (o_rd_k),
        .i_enable (fmt == FMT_ONE),
        .i_data   (i_ak_data),
        .o_value  (ak_v),
        .o_check  (ak_c)
    );
    tpd_zero_sub #(.W(S_W), .SPECIAL(S_SPECIAL_J)) u_sj (
        .i_desig  (o_rd_j),
        .i_enable (fmt == FMT_ONE),
        .i_data   (i_sj_data),
        .o_value  (sj_v),
        .o_check  (sj_c)
    );
    tpd_zero_sub #(.W(S_W), .SPECIAL(S_SPECIAL_K)) u_sk (
        .i_desig  (o_rd_k),
        .i_enable (fmt == FMT_ONE),
        .i_data   (i_sk_data),
        .o_value  (sk_v),
        .o_check  (sk_c)
    );

    // fetch word holding register
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            word_q     <= WORD_RST;
            word_vld_q <= 1'b0;
        end else if (i_redirect) begin
            word_vld_q <= 1'b0;                 // flush on branch
        end else if (load) begin
            word_q     <= i_word;
            word_vld_q <= 1'b1;
        end else if (word_done) begin
            word_vld_q <= 1'b0;
        end
    end

    // parcel pointer; wraps to parcel 0 of the next word
    always_comb begin
        ptr_d = ptr_q;
        if (i_redirect) begin
            ptr_d = i_redirect_parcel;          // any parcel may be a target
        end else if (issue_sp) begin
            ptr_d = 2'h1;
        end else if (issue_in) begin
            ptr_d = 2'(ptr_q + 2'h2);
        end else if (issue_one) begin
            ptr_d = 2'(ptr_q + 2'h1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            ptr_q <= PTR_RST;
        end else begin
            ptr_q <= ptr_d;
        end
    end

    // split state and the held leading parcel
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            state_q <= ST_RUN;
            first_q <= 16'h0000;
        end else if (i_redirect) begin
            state_q <= ST_RUN;                  // abandon a half instruction
        end else if (split) begin
            state_q <= ST_SPLIT;
            first_q <= cur;
        end else if (issue_sp) begin
            state_q <= ST_RUN;
        end
    end

    // issued fields; register zero stores are never written
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_issue  <= 1'b0;
            o_format <= FMT_ONE;
            o_gh     <= 7'h00;
            o_h      <= 3'h0;
            o_i      <= 3'h0;
            o_imm22  <= 22'h00_0000;
            o_imm24  <= 24'h00_0000;
            o_target <= 24'h00_0000;
        end else begin
            o_issue  <= issue && !i_redirect;
            if (issue) begin
                o_format <= fmt;
                o_gh     <= inst[F_GH_LO +: 7];
                o_h      <= inst[F_H_LO +: 3];
                o_i      <= inst[F_I_LO +: 3];
                o_imm22  <= inst[IMM22_W-1:0];
                o_imm24  <= inst[IMM24_W-1:0];
                o_target <= inst[IMM24_W-1:0];
            end
        end
    end

    // operand values and check flags captured at issue
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_ah     <= 24'h00_0000;
            o_ai     <= 24'h00_0000;
            o_aj     <= 24'h00_0000;
            o_ak     <= 24'h00_0000;
            o_si     <= 64'h0;
            o_sj     <= 64'h0;
            o_sk     <= 64'h0;
            o_chk_ah <= 1'b0;
            o_chk_aj <= 1'b0;
            o_chk_ak <= 1'b0;
            o_chk_sj <= 1'b0;
            o_chk_sk <= 1'b0;
        end else if (issue) begin
            o_ah     <= ah_v;
            o_ai     <= i_ai_data;
            o_aj     <= aj_v;
            o_ak     <= ak_v;
            o_si     <= i_si_data;
            o_sj     <= sj_v;
            o_sk     <= sk_v;
            o_chk_ah <= ah_c;
            o_chk_aj <= aj_c;
            o_chk_ak <= ak_c;
            o_chk_sj <= sj_c;
            o_chk_sk <= sk_c;
        end
    end

    // vector length enter takes the k operand, one when k is zero
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_veclen_we   <= 1'b0;
            o_veclen_data <= 7'h00;
        end else begin
            o_veclen_we <= issue && !i_redirect && fmt == FMT_ONE &&
                           inst[F_GH_LO +: 7] == GH_VECLEN;
            if (issue && fmt == FMT_ONE && inst[F_GH_LO +: 7] == GH_VECLEN) begin
                o_veclen_data <= ak_v[VECLEN_W-1:0];
            end
        end
    end

    // checks
    sequence split_seen;
        split && !i_redirect;
    endsequence

    sequence half_landed;
        state_q == ST_SPLIT && !o_issue;
    endsequence

    imm22_fields_a: assert property (issue && fmt == FMT_IMM22 |=>
        o_imm22 == $past(inst[21:0]) && o_i == $past(inst[24:22]) && o_gh == $past(inst[31:25]))
        else $error("immediate-22 fields wrong");
    mem_fields_a: assert property (issue && fmt == FMT_MEM |=>
        o_format == FMT_MEM && o_h == $past(inst[27:25]) && o_imm22 == $past(inst[21:0]))
        else $error("memory fields wrong");
    branch_target_a: assert property (issue && fmt == FMT_BRANCH && !i_redirect |=>
        o_issue && o_target == $past(inst[23:0]) && !$past(inst[24]))
        else $error("branch target wrong");
    imm24_value_a: assert property (issue && fmt == FMT_IMM24 |=>
        o_imm24 == $past(inst[23:0]) && $past(inst[24]))
        else $error("immediate-24 wrong");
    a_zero_sub_a: assert property (issue && fmt == FMT_ONE && o_rd_k == 3'h0 && o_rd_j == 3'h0 |=>
        o_ak == 24'h00_0001 && o_aj == 24'h00_0000)
        else $error("address zero substitution wrong");
    s_zero_sub_a: assert property (issue && fmt == FMT_ONE && o_rd_k == 3'h0 |=>
        o_sk == 64'h8000_0000_0000_0000)
        else $error("scalar sign operand wrong");
    zero_no_check_a: assert property (issue && fmt == FMT_ONE && o_rd_j == 3'h0 |=>
        !o_chk_aj && !o_chk_sj)
        else $error("reservation check on zero");
    true_i_read_a: assert property (issue |=> o_ai == $past(i_ai_data) && o_si == $past(i_si_data))
        else $error("i operand not true contents");
    veclen_one_a: assert property (issue && !i_redirect && inst[31:16] == 16'h0400 |=>
        o_veclen_we && o_veclen_data == 7'h01)
        else $error("vector length not one");
    parcel_step_a: assert property (issue_one && !i_redirect |=> ptr_q == $past(ptr_q) + 2'h1)
        else $error("parcel pointer step wrong");
    split_hold_a: assert property (split_seen |=> half_landed)
        else $error("split issued early");
endmodule
`default_nettype wire

/* File: rtl/tpd_pkg.sv */
// constants, types and helpers for the two-parcel format and operand decoder
// assumes one cpu clock; parcels are 16 bits, packed four to a 64-bit word
//
// Behaviour
// - immediate-22 type: 7-bit opcode, destination, 22-bit constant
// - memory type: 4-bit opcode, index, register, 22-bit displacement
// - branch type: 7-bit opcode, 24-bit parcel target
// - immediate-24 type: set i top bit, 24-bit constant
// - address reg zero gives zero, or one
// - scalar reg zero gives zero, or sign bit
// - special operands skip reservation check on zero
// - special operands never alter stored register zero
// - register zero in i field reads true contents
// - code 002000 loads one into vector length
// - four parcels per word, instructions span words
package tpd_pkg;

    // widths
    localparam int PARCEL_W = 16;                   // one instruction parcel
    localparam int WORD_W   = 64;                   // one fetched word
    localparam int INST_W   = 32;                   // two parcels joined
    localparam int A_W      = 24;                   // address register width
    localparam int S_W      = 64;                   // scalar register width
    localparam int IMM22_W  = 22;                   // jkm constant
    localparam int IMM24_W  = 24;                   // ijkm constant or target
    localparam int VECLEN_W = 7;                    // vector length register

    // field positions inside the joined instruction
    localparam int F_G_LO   = 28;                   // g, 4 bits
    localparam int F_H_LO   = 25;                   // h, 3 bits
    localparam int F_I_LO   = 22;                   // i, 3 bits
    localparam int F_J_LO   = 19;                   // j, 3 bits
    localparam int F_K_LO   = 16;                   // k, 3 bits
    localparam int F_GH_LO  = 25;                   // gh, 7 bits
    localparam int F_ITOP   = 24;                   // top bit of i

    // opcodes
    localparam logic [6:0] GH_VECLEN   = 7'h02;     // enter vector length from ak
    localparam logic [6:0] GH_IMM22_A  = 7'h10;     // 22-bit constant to a register
    localparam logic [6:0] GH_IMM22_S  = 7'h20;     // 22-bit constant to s register
    localparam logic [6:0] GH_BR_LO    = 7'h06;     // first two-parcel branch
    localparam logic [6:0] GH_BR_HI    = 7'h0f;     // last two-parcel branch
    localparam logic [3:0] G_IMM24     = 4'h2;      // 24-bit constant, i top set
    localparam logic [3:0] G_MEM_LO    = 4'h8;      // first scalar memory opcode
    localparam logic [3:0] G_MEM_HI    = 4'hb;      // last scalar memory opcode

    // special operand values
    localparam logic [A_W-1:0] A_SPECIAL_H = 24'h00_0000;            // ah, h=0
    localparam logic [A_W-1:0] A_SPECIAL_J = 24'h00_0000;            // aj, j=0
    localparam logic [A_W-1:0] A_SPECIAL_K = 24'h00_0001;            // ak, k=0
    localparam logic [S_W-1:0] S_SPECIAL_J = 64'h0000_0000_0000_0000; // sj, j=0
    localparam logic [S_W-1:0] S_SPECIAL_K = 64'h8000_0000_0000_0000; // sk, k=0

    // reset values
    localparam logic [1:0]      PTR_RST  = 2'h0;
    localparam logic [WORD_W-1:0] WORD_RST = 64'h0;

    // instruction format seen at issue
    typedef enum logic [2:0] {
        FMT_ONE    = 3'b000,
        FMT_IMM22  = 3'b001,
        FMT_MEM    = 3'b010,
        FMT_BRANCH = 3'b011,
        FMT_IMM24  = 3'b100
    } tpd_fmt_e;

    // parcel engine state
    typedef enum logic {
        ST_RUN   = 1'b0,
        ST_SPLIT = 1'b1
    } tpd_state_e;

    // two-parcel test made on the leading parcel only
    function automatic logic tpd_two_parcel(input logic [PARCEL_W-1:0] p);
        logic [6:0] gh;
        logic [3:0] g;
        gh = p[15:9];
        g  = p[15:12];
        tpd_two_parcel = (gh == GH_IMM22_A) || (gh == GH_IMM22_S) ||
                         (gh >= GH_BR_LO && gh <= GH_BR_HI) ||
                         (g == G_IMM24) ||
                         (g >= G_MEM_LO && g <= G_MEM_HI);
    endfunction

endpackage

/* File: rtl/tpd_zero_sub.sv */
// register zero operand substitution for one designator field
// assumes i_data is the register file read for the same designator
`timescale 1ns/1ps
`default_nettype none
module tpd_zero_sub #(
    parameter int               W       = 24,   // operand width
    parameter logic [W-1:0]     SPECIAL = '0    // value given for register zero
) (
    input  wire logic [2:0]     i_desig,        // register designator
    input  wire logic           i_enable,       // field takes special meaning
    input  wire logic [W-1:0]   i_data,         // stored register contents
    output logic      [W-1:0]   o_value,        // operand handed on
    output logic                o_check         // reservation check needed
);
    logic zero_hit;                             // register zero named here

    // substitute the generated value; the stored copy is only read
    always_comb begin
        zero_hit = i_enable && (i_desig == 3'h0);
        o_value  = zero_hit ? SPECIAL : i_data;
        o_check  = !zero_hit;
    end
endmodule
`default_nettype wire

/* File: testbench/tpd_decode_tb.sv */
// self-checking bench for the two-parcel format and operand decoder
// assumes a combinational register file answering on the read addresses
`timescale 1ns/1ps
`default_nettype none
module two_parcel_format_operand_decode_tb;
    import tpd_pkg::*;
    localparam logic [15:0] NOP  = 16'h3249;           // one-parcel filler, no zero fields
    localparam logic [20:0] AREG = 21'h1a5;            // a register pattern above address
    localparam logic [60:0] SREG = 61'h0abc_def0_1234; // s register pattern above address
    logic        i_clk, i_nrst, i_word_valid, o_word_ready, i_redirect, o_issue, o_veclen_we;
    logic        o_chk_ah, o_chk_aj, o_chk_ak, o_chk_sj, o_chk_sk;
    logic [1:0]  i_redirect_parcel;
    logic [2:0]  o_rd_h, o_rd_i, o_rd_j, o_rd_k, o_h, o_i;
    logic [6:0]  o_gh, o_veclen_data;
    logic [21:0] o_imm22;
    logic [23:0] i_ah_data, i_ai_data, i_aj_data, i_ak_data, o_imm24, o_target, o_ah, o_ai, o_aj, o_ak;
    logic [63:0] i_word, i_si_data, i_sj_data, i_sk_data, o_si, o_sj, o_sk;
    tpd_fmt_e    o_format;
    int          err_total, checks;
    tpd_decode dut (.i_clk, .i_nrst, .i_word_valid, .i_word, .o_word_ready, .i_redirect,
        .i_redirect_parcel, .o_rd_h, .o_rd_i, .o_rd_j, .o_rd_k, .i_ah_data, .i_ai_data, .i_aj_data,
        .i_ak_data, .i_si_data, .i_sj_data, .i_sk_data, .o_issue, .o_format, .o_gh, .o_h, .o_i,
        .o_imm22, .o_imm24, .o_target, .o_ah, .o_ai, .o_aj, .o_ak, .o_si, .o_sj, .o_sk, .o_chk_ah,
        .o_chk_aj, .o_chk_ak, .o_chk_sj, .o_chk_sk, .o_veclen_we, .o_veclen_data);
    // register file: contents carry the address so a wrong read shows up
    assign i_ah_data = {AREG, o_rd_h};
    assign i_ai_data = {AREG, o_rd_i};
    assign i_aj_data = {AREG, o_rd_j};
    assign i_ak_data = {AREG, o_rd_k};
    assign i_si_data = {SREG, o_rd_i};
    assign i_sj_data = {SREG, o_rd_j};
    assign i_sk_data = {SREG, o_rd_k};
    // compare one value, count and report
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // offer one word, hold it until ready is seen at an edge
    task automatic put(input logic [63:0] w);
        int   n;
        logic ok;
        n = 0;
        #1 i_word_valid = 1'b1;
        i_word = w;
        do begin
            @(negedge i_clk) ok = o_word_ready;
            @(posedge i_clk);
            n++;
        end while (ok !== 1'b1 && n < 50);
        if (ok !== 1'b1) chk(64'h0, 64'h1);
    endtask
    // two words back to back, then the fetch side goes idle
    task automatic feed(input logic [63:0] w1, input logic [63:0] w2);
        put(w1);
        put(w2);
        #1 i_word_valid = 1'b0;
    endtask
    // next issue pulse, bounded
    task automatic wait_issue();
        int n;
        n = 0;
        do begin
            @(posedge i_clk);
            #1 n++;
        end while (o_issue !== 1'b1 && n < 20);
        chk(64'(o_issue), 64'h1);
    endtask
    // let leftover filler issue before the next test
    task automatic drain();
        repeat (12) @(posedge i_clk);
    endtask
    // code 002000 with k zero enters one into vector length
    task automatic t_veclen_enter();
        fork
            feed({16'h0400, NOP, NOP, NOP}, {4{NOP}});
            begin
                wait_issue();
                chk(64'({o_veclen_we, o_veclen_data}), 64'h81);
                chk(64'({o_ak, o_chk_ak}), 64'h2);
            end
        join
        drain();
        $display("test veclen_enter done");
    endtask
    // zero designators give special operands, non-zero read true contents
    task automatic t_zero_ops();
        fork
            feed({16'h3200, 16'h321d, NOP, NOP}, {4{NOP}});
            begin
                wait_issue();
                chk(64'({o_aj, o_ak}), 64'h1);
                chk(o_sj, 64'h0);
                chk(o_sk, 64'h8000_0000_0000_0000);
                chk(64'({o_chk_aj, o_chk_ak, o_chk_sj, o_chk_sk}), 64'h0);
                chk(64'(o_ai), 64'({AREG, 3'h0}));
                chk(o_si, {SREG, 3'h0});
                wait_issue();
                chk(64'({o_aj, o_ak}), 64'({AREG, 3'h3, AREG, 3'h5}));
                chk(o_sk, {SREG, 3'h5});
                chk(64'({o_chk_aj, o_chk_ak, o_chk_sj, o_chk_sk}), 64'hf);
            end
        join
        drain();
        $display("test zero_ops done");
    endtask
    // 22-bit constant starting in parcel 3, finished by the next word
    task automatic t_split_imm22();
        fork
            feed({NOP, NOP, NOP, 16'h20ed}, {16'hbeef, NOP, NOP, NOP});
            begin
                repeat (4) wait_issue();
                chk(64'(o_format), 64'(FMT_IMM22));
                chk(64'({o_gh, o_i, o_imm22}), 64'({7'h10, 3'h3, 22'h2dbeef}));
            end
        join
        drain();
        $display("test split_imm22 done");
    endtask
    // branch, memory with index zero, then 24-bit constant, back to back
    task automatic t_branch_mem_imm24();
        fork
            feed({16'h0ed5, 16'h1234, 16'h918a, 16'h4321}, {16'h29bc, 16'h00ff, NOP, NOP});
            begin
                wait_issue();
                chk(64'({o_format, o_gh, o_target}), 64'({FMT_BRANCH, 7'h07, 24'hd51234}));
                wait_issue();
                chk(64'({o_format, o_h, o_i, o_imm22}), 64'({FMT_MEM, 3'h0, 3'h6, 22'h0a4321}));
                chk(64'({o_ah, o_chk_ah}), 64'h0);
                wait_issue();
                chk(64'({o_format, o_h, o_imm24}), 64'({FMT_IMM24, 3'h4, 24'hbc00ff}));
            end
        join
        drain();
        $display("test branch_mem_imm24 done");
    endtask
    // redirect to parcel 2: the next word's first two parcels are skipped
    task automatic t_redirect();
        #1 i_redirect = 1'b1;
        i_redirect_parcel = 2'h2;
        @(posedge i_clk);
        fork
            #1 i_redirect = 1'b0;
            feed({16'h20ed, 16'hbeef, 16'h0ed5, 16'h1234}, {4{NOP}});
            begin
                wait_issue();
                chk(64'({o_format, o_target}), 64'({FMT_BRANCH, 24'hd51234}));
            end
        join
        drain();
        $display("test redirect done");
    endtask
    // print counts and verdict, end the run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // 100 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // tests take some 100 cycles; twenty times that means a hang
    initial begin
        #20000;
        err_total++;
        complete_run();
    end
    // reset, then the tests in turn
    initial begin
        {i_nrst, i_word_valid, i_redirect, i_redirect_parcel, i_word} = '0;
        err_total = 0;
        checks = 0;
        repeat (16) @(posedge i_clk);
        #1 i_nrst = 1'b1;
        chk(64'({o_issue, o_word_ready}), 64'h1);
        @(posedge i_clk);
        t_veclen_enter();
        t_zero_ops();
        t_split_imm22();
        t_branch_mem_imm24();
        t_redirect();
        complete_run();
    end
endmodule
`default_nettype wire
